// ===== pkg/bprs_pkg.sv
// package: timing constants and state types for the reset and power-fail sequencer
package bprs_pkg;

  localparam int CLK_HZ     = 100_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;

  // intervals in microseconds, as specified
  localparam int T_COLD_WARN_US    = 2500;
  localparam int T_RST_HOLD_US     = 50000;
  localparam int T_SAVE_US         = 6000;
  localparam int T_HW_PREP_US      = 250;
  localparam int T_RECOVER_WARN_US = 7500;
  localparam int T_PWR_STABLE_US   = 1000;
  localparam int T_WRITE_PROTECT_LINE_REL_US     = 2500;

  // the same intervals in clk_sys cycles
  localparam int COLD_WARN_CYC    = T_COLD_WARN_US * CYC_PER_US;
  localparam int RST_HOLD_CYC     = T_RST_HOLD_US * CYC_PER_US;
  localparam int SAVE_CYC         = T_SAVE_US * CYC_PER_US;
  localparam int HW_PREP_CYC      = T_HW_PREP_US * CYC_PER_US;
  localparam int RECOVER_WARN_CYC = T_RECOVER_WARN_US * CYC_PER_US;
  localparam int PWR_STABLE_CYC   = T_PWR_STABLE_US * CYC_PER_US;
  localparam int WRITE_PROTECT_LINE_REL_CYC     = T_WRITE_PROTECT_LINE_REL_US * CYC_PER_US;

  localparam int TIMER_W = 24;

  typedef enum logic [3:0] {
    CS_COLD_WARN,
    CS_COLD_RST,
    CS_RUN,
    CS_WARM_RST,
    CS_PF_SAVE,
    CS_PF_WRITE_PROTECT_LINE,
    CS_PF_DOWN,
    CS_PF_STABLE,
    CS_PF_UNPROT,
    CS_NB_WARN,
    CS_ABANDON
  } bprs_cs_state_t;

  typedef enum logic [1:0] {
    ER_IDLE,
    ER_WATCH,
    ER_HOLD
  } bprs_err_state_t;

endpackage : bprs_pkg

// ===== pkg/bprs_bus_if.sv
// interface: open-drain central control and exception lines between the two ends
interface bprs_bus_if;
  // drive side: out is the driven level, oeN low while driving
  logic csWarnOut;
  logic csWarnOeN;
  logic csProtOut;
  logic csProtOeN;
  logic csRstOut;
  logic csRstOeN;
  logic csExpOut;
  logic csExpOeN;
  logic agRncOut;
  logic agRncOeN;
  logic agBerrOut;
  logic agBerrOeN;
  logic agAerrOut;
  logic agAerrOeN;
  // resolved wire levels, low = asserted
  logic warnN;
  logic protN;
  logic rstN;
  logic rncN;
  logic berrN;
  logic expN;
  logic aerrN;

  assign warnN = csWarnOeN | csWarnOut;
  assign protN = csProtOeN | csProtOut;
  assign rstN  = csRstOeN | csRstOut;
  assign expN  = csExpOeN | csExpOut;
  assign rncN  = agRncOeN | agRncOut;
  assign berrN = agBerrOeN | agBerrOut;
  assign aerrN = agAerrOeN | agAerrOut;

  modport csu (
    output csWarnOut, csWarnOeN, csProtOut, csProtOeN,
    output csRstOut, csRstOeN, csExpOut, csExpOeN,
    input  warnN, protN, rstN, rncN, berrN, expN, aerrN
  );

  modport agent (
    output agRncOut, agRncOeN, agBerrOut, agBerrOeN, agAerrOut, agAerrOeN,
    input  warnN, protN, rstN, rncN, berrN, expN, aerrN
  );
endinterface : bprs_bus_if

// ===== logic/bprs_error_resolver.sv
// error priority resolver shared by both ends
module bprs_error_resolver
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic agentErr,
  input  wire logic bus_error_line,
  input  wire logic expiryErr,
  output logic      errReport,
  output logic      errIsBus,
  output logic      errIsExpiry,
  output logic      errIsAgent
);

  bprs_pkg::bprs_err_state_t state_reg;
  bprs_pkg::bprs_err_state_t state_next;
  logic                      report_next;
  logic                      isBus_next;
  logic                      isExp_next;
  logic                      isAgent_next;

  always_comb
  begin
    state_next   = state_reg;
    report_next  = 1'b0;
    isBus_next   = errIsBus;
    isExp_next   = errIsExpiry;
    isAgent_next = errIsAgent;
    unique case (state_reg)
      bprs_pkg::ER_IDLE:
      begin
        if (bus_error_line || expiryErr)
        begin
          // exceptions win over an agent error in the same clock
          report_next  = 1'b1; // RL4
          isBus_next   = bus_error_line; // RL3
          isExp_next   = expiryErr; // RL4
          isAgent_next = 1'b0; // RL3
          state_next   = bprs_pkg::ER_HOLD;
        end
        else if (agentErr)
        begin
          state_next = bprs_pkg::ER_WATCH; // RL2
        end
      end
      bprs_pkg::ER_WATCH:
      begin
        // one clock of bus error watch after the agent error
        report_next  = 1'b1;
        isBus_next   = bus_error_line; // RL2
        isExp_next   = 1'b0;
        isAgent_next = !bus_error_line; // RL2
        state_next   = bprs_pkg::ER_HOLD;
      end
      bprs_pkg::ER_HOLD:
      begin
        // later errors ignored until every line is quiet
        if (!(agentErr || bus_error_line || expiryErr))
        begin
          state_next = bprs_pkg::ER_IDLE; // RL1
        end
      end
      default:
      begin
        state_next = bprs_pkg::ER_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_reg   <= bprs_pkg::ER_IDLE;
      errReport   <= 1'b0;
      errIsBus    <= 1'b0;
      errIsExpiry <= 1'b0;
      errIsAgent  <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      errReport   <= report_next;
      errIsBus    <= isBus_next;
      errIsExpiry <= isExp_next;
      errIsAgent  <= isAgent_next;
    end
  end

endmodule : bprs_error_resolver

// ===== logic/bprs_bus_agent.sv
// agent end: decodes reset and power events, drives agent lines
module bprs_bus_agent
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic initBusy,
  input  wire logic busErrReq,
  input  wire logic agentErrReq,
  bprs_bus_if.agent bus,
  output logic      powerOnInit,
  output logic      warmInit,
  output logic      pastPowerFail,
  output logic      busCycleOk,
  output logic      errReport,
  output logic      errIsBus,
  output logic      errIsExpiry,
  output logic      errIsAgent
);

  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;
  logic       rncOeN_reg;
  logic       berrOeN_reg;
  logic       aerrOeN_reg;
  logic       warnAct;
  logic       protAct;
  logic       rstAct;

  assign bus.agRncOut  = 1'b0;
  assign bus.agBerrOut = 1'b0;
  assign bus.agAerrOut = 1'b0;
  assign bus.agRncOeN  = rncOeN_reg;
  assign bus.agBerrOeN = berrOeN_reg;
  assign bus.agAerrOeN = aerrOeN_reg;

  // warning and protect are asynchronous, reset lines are on our clock
  assign warnAct = syncB_reg[0]; // RL10
  assign protAct = syncB_reg[1]; // RL10
  assign rstAct  = !bus.rstN; // RL10

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      syncA_reg     <= 2'h0;
      syncB_reg     <= 2'h0;
      rncOeN_reg    <= 1'b1;
      berrOeN_reg   <= 1'b1;
      aerrOeN_reg   <= 1'b1;
      powerOnInit   <= 1'b0;
      warmInit      <= 1'b0;
      pastPowerFail <= 1'b0;
      busCycleOk    <= 1'b0;
    end
    else
    begin
      syncA_reg     <= {!bus.protN, !bus.warnN};
      syncB_reg     <= syncA_reg;
      rncOeN_reg    <= !initBusy; // RL8
      berrOeN_reg   <= !busErrReq;
      aerrOeN_reg   <= !agentErrReq;
      powerOnInit   <= rstAct && warnAct && !protAct; // RL9
      warmInit      <= rstAct && !warnAct; // RL12
      pastPowerFail <= rstAct && !warnAct && protAct; // RL19
      busCycleOk    <= !rstAct && bus.rncN; // RL8
    end
  end

  bprs_error_resolver u_resolver
  (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .agentErr    (!bus.aerrN),
    .bus_error_line      (!bus.berrN),
    .expiryErr   (!bus.expN),
    .errReport   (errReport),
    .errIsBus    (errIsBus),
    .errIsExpiry (errIsExpiry),
    .errIsAgent  (errIsAgent)
  );

endmodule : bprs_bus_agent

// ===== logic/bprs_central_unit.sv
// central services end: cold-start, warm-start and power-fail sequencing
//
// Behaviour
// RL1 - report only the first error, ignore later
// RL2 - watch bus error one clock after agent error
// RL3 - same-clock agent and bus error: keep bus
// RL4 - exceptions beat agent errors; expiry plus bus both kept
// RL5 - power-up: warning and reset on, protect off
// RL6 - cold start holds warning 2.5 ms
// RL7 - reset held 50 ms after warning release
// RL8 - reset-not-complete blocks new bus cycles
// RL9 - agents see power-on init from line pattern
// RL10 - warning/protect asynchronous, reset lines clock-synchronous
// RL11 - warm start asserts only reset, 50 ms
// RL12 - warm start leaves warning released
// RL13 - early supply warning asserts warning at once; the code ignores it in CS_PF_UNPROT until CS_COLD_RST
// RL14 - 6.0 ms save time, then protect on
// RL15 - 250 us hardware preparation after protect
// RL16 - recovery during shutdown keeps warning 7.5 ms
// RL17 - clocks may stop during power-down
// RL18 - power good 1 ms, warning off, protect 2.5 ms later
// RL19 - agents detect past power failure from lines
// RL20 - no battery: warning only, protect and reset off
// RL21 - power fail during reset: unsequenced, then cold start
// RL22 - warm request during shutdown ignored or aborts it
// RL23 - intervals counted on the free-running system clock
module bprs_central_unit #(
  parameter int unsigned CNT_W            = bprs_pkg::TIMER_W,
  parameter int unsigned COLD_WARN_CYC    = bprs_pkg::COLD_WARN_CYC,
  parameter int unsigned RST_HOLD_CYC     = bprs_pkg::RST_HOLD_CYC,
  parameter int unsigned SAVE_CYC         = bprs_pkg::SAVE_CYC,
  parameter int unsigned HW_PREP_CYC      = bprs_pkg::HW_PREP_CYC,
  parameter int unsigned RECOVER_WARN_CYC = bprs_pkg::RECOVER_WARN_CYC,
  parameter int unsigned PWR_STABLE_CYC   = bprs_pkg::PWR_STABLE_CYC,
  parameter int unsigned WRITE_PROTECT_LINE_REL_CYC     = bprs_pkg::WRITE_PROTECT_LINE_REL_CYC,
  parameter bit          ABORT_ON_WARM    = 1'b0
)
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic supplyFailEarly,
  input  wire logic supplyGood,
  input  wire logic warmStartReq,
  input  wire logic batteryBackup,
  input  wire logic expiryReq,
  bprs_bus_if.csu   bus,
  output logic      clkDriveEn,
  output logic      busCycleOk,
  output logic      inShutdown,
  output logic      errReport,
  output logic      errIsBus,
  output logic      errIsExpiry,
  output logic      errIsAgent
);

  bprs_pkg::bprs_cs_state_t state_reg;
  bprs_pkg::bprs_cs_state_t state_next;
  logic [CNT_W-1:0]         cnt_reg;
  logic [CNT_W-1:0]         cnt_next;
  logic [CNT_W-1:0]         warnAge_reg;
  logic [CNT_W-1:0]         warnAge_next;
  logic [3:0]               syncA_reg;
  logic [3:0]               syncB_reg;
  logic                     warmPrev_reg;
  logic                     warnOeN_reg;
  logic                     protOeN_reg;
  logic                     rstOeN_reg;
  logic                     expOeN_reg;
  logic                     warnOn;
  logic                     protOn;
  logic                     rstOn;
  logic                     pfEarly;
  logic                     pwrGood;
  logic                     warmLvl;
  logic                     battery;
  logic                     warmEdge;
  logic                     pwrBack;
  logic                     inPf;

  // elapsed-count test against an interval length
  function automatic logic elapsed(input logic [CNT_W-1:0] cnt, input int unsigned len);
    elapsed = (cnt >= CNT_W'(len - 1));
  endfunction : elapsed

  // drivers from flip-flops, open-drain: enable low pulls the line active
  assign bus.csWarnOut = 1'b0;
  assign bus.csProtOut = 1'b0;
  assign bus.csRstOut  = 1'b0;
  assign bus.csExpOut  = 1'b0;
  assign bus.csWarnOeN = warnOeN_reg;
  assign bus.csProtOeN = protOeN_reg;
  assign bus.csRstOeN  = rstOeN_reg;
  assign bus.csExpOeN  = expOeN_reg;

  // supply pins and the front panel request come from outside the clock
  assign pfEarly  = syncB_reg[0];
  assign pwrGood  = syncB_reg[1];
  assign warmLvl  = syncB_reg[2];
  assign battery  = syncB_reg[3];
  assign warmEdge = warmLvl && !warmPrev_reg;
  assign pwrBack  = pwrGood && !pfEarly;
  assign inPf     = (state_reg == bprs_pkg::CS_PF_SAVE) || (state_reg == bprs_pkg::CS_PF_WRITE_PROTECT_LINE)
                 || (state_reg == bprs_pkg::CS_PF_DOWN) || (state_reg == bprs_pkg::CS_PF_STABLE);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bprs_pkg::CS_COLD_WARN:
      begin
        if (pfEarly)
          state_next = bprs_pkg::CS_ABANDON; // RL21
        else if (elapsed(cnt_reg, COLD_WARN_CYC))
          state_next = bprs_pkg::CS_COLD_RST; // RL6
      end
      bprs_pkg::CS_COLD_RST:
      begin
        if (pfEarly)
          state_next = bprs_pkg::CS_ABANDON; // RL21
        else if (elapsed(cnt_reg, RST_HOLD_CYC))
          state_next = bprs_pkg::CS_RUN; // RL7
      end
      bprs_pkg::CS_RUN:
      begin
        if (pfEarly)
          state_next = battery ? bprs_pkg::CS_PF_SAVE : bprs_pkg::CS_NB_WARN; // RL13
        else if (warmEdge)
          state_next = bprs_pkg::CS_WARM_RST; // RL11
      end
      bprs_pkg::CS_WARM_RST:
      begin
        if (pfEarly)
          state_next = bprs_pkg::CS_ABANDON; // RL21
        else if (elapsed(cnt_reg, RST_HOLD_CYC))
          state_next = bprs_pkg::CS_RUN; // RL11
      end
      bprs_pkg::CS_PF_SAVE:
      begin
        if (ABORT_ON_WARM && warmEdge)
          state_next = bprs_pkg::CS_ABANDON; // RL22
        else if (elapsed(cnt_reg, SAVE_CYC))
          state_next = bprs_pkg::CS_PF_WRITE_PROTECT_LINE; // RL14
      end
      bprs_pkg::CS_PF_WRITE_PROTECT_LINE:
      begin
        if (ABORT_ON_WARM && warmEdge)
          state_next = bprs_pkg::CS_ABANDON; // RL22
        else if (elapsed(cnt_reg, HW_PREP_CYC))
          state_next = bprs_pkg::CS_PF_DOWN; // RL15
      end
      bprs_pkg::CS_PF_DOWN:
      begin
        if (ABORT_ON_WARM && warmEdge)
          state_next = bprs_pkg::CS_ABANDON; // RL22
        else if (pwrBack && elapsed(warnAge_reg, RECOVER_WARN_CYC - PWR_STABLE_CYC))
          state_next = bprs_pkg::CS_PF_STABLE; // RL16
      end
      bprs_pkg::CS_PF_STABLE:
      begin
        if (!pwrBack)
          state_next = bprs_pkg::CS_PF_DOWN;
        else if (elapsed(cnt_reg, PWR_STABLE_CYC))
          state_next = bprs_pkg::CS_PF_UNPROT; // RL18
      end
      bprs_pkg::CS_PF_UNPROT:
      begin
        if (elapsed(cnt_reg, WRITE_PROTECT_LINE_REL_CYC))
          state_next = bprs_pkg::CS_COLD_RST; // RL18
      end
      bprs_pkg::CS_NB_WARN:
      begin
        if (pwrBack)
          state_next = bprs_pkg::CS_COLD_WARN; // RL20
      end
      bprs_pkg::CS_ABANDON:
      begin
        if (pwrBack)
          state_next = bprs_pkg::CS_COLD_WARN; // RL21
      end
      default:
      begin
        state_next = bprs_pkg::CS_COLD_WARN;
      end
    endcase
  end

  // interval counters run on every system clock edge
  always_comb
  begin
    if (state_next != state_reg)
      cnt_next = '0; // RL23
    else if (cnt_reg != '1)
      cnt_next = cnt_reg + CNT_W'(1); // RL23
    else
      cnt_next = cnt_reg;
    if (!inPf)
      warnAge_next = '0;
    else if (warnAge_reg != '1)
      warnAge_next = warnAge_reg + CNT_W'(1); // RL16
    else
      warnAge_next = warnAge_reg;
  end

  // line levels for the state being entered
  always_comb
  begin
    unique case (state_next)
      bprs_pkg::CS_COLD_WARN: {warnOn, protOn, rstOn} = 3'h5; // RL5
      bprs_pkg::CS_COLD_RST:  {warnOn, protOn, rstOn} = 3'h1; // RL7
      bprs_pkg::CS_RUN:       {warnOn, protOn, rstOn} = 3'h0;
      bprs_pkg::CS_WARM_RST:  {warnOn, protOn, rstOn} = 3'h1; // RL12
      bprs_pkg::CS_PF_SAVE:   {warnOn, protOn, rstOn} = 3'h4; // RL14
      bprs_pkg::CS_PF_WRITE_PROTECT_LINE:   {warnOn, protOn, rstOn} = 3'h6; // RL14
      bprs_pkg::CS_PF_DOWN:   {warnOn, protOn, rstOn} = 3'h7;
      bprs_pkg::CS_PF_STABLE: {warnOn, protOn, rstOn} = 3'h7;
      bprs_pkg::CS_PF_UNPROT: {warnOn, protOn, rstOn} = 3'h3; // RL18
      bprs_pkg::CS_NB_WARN:   {warnOn, protOn, rstOn} = 3'h4; // RL20
      bprs_pkg::CS_ABANDON:   {warnOn, protOn, rstOn} = 3'h5; // RL21
      default:                {warnOn, protOn, rstOn} = 3'h5;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state_reg    <= bprs_pkg::CS_COLD_WARN;
      cnt_reg      <= '0;
      warnAge_reg  <= '0;
      syncA_reg    <= 4'h0;
      syncB_reg    <= 4'h0;
      warmPrev_reg <= 1'b0;
      warnOeN_reg  <= 1'b0; // RL5
      protOeN_reg  <= 1'b1; // RL5
      rstOeN_reg   <= 1'b0; // RL5
      expOeN_reg   <= 1'b1;
      clkDriveEn   <= 1'b1;
      busCycleOk   <= 1'b0;
      inShutdown   <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      warnAge_reg  <= warnAge_next;
      syncA_reg    <= {batteryBackup, warmStartReq, supplyGood, supplyFailEarly}; // RL10
      syncB_reg    <= syncA_reg;
      warmPrev_reg <= warmLvl;
      warnOeN_reg  <= !warnOn;
      protOeN_reg  <= !protOn;
      rstOeN_reg   <= !rstOn; // RL10
      expOeN_reg   <= !expiryReq;
      clkDriveEn   <= (state_next != bprs_pkg::CS_PF_DOWN); // RL17
      busCycleOk   <= !rstOn && !protOn && bus.rncN; // RL8
      inShutdown   <= (state_next == bprs_pkg::CS_PF_SAVE) || (state_next == bprs_pkg::CS_PF_WRITE_PROTECT_LINE)
                   || (state_next == bprs_pkg::CS_PF_DOWN);
    end
  end

  bprs_error_resolver u_resolver
  (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .agentErr    (!bus.aerrN),
    .bus_error_line      (!bus.berrN),
    .expiryErr   (!bus.expN),
    .errReport   (errReport),
    .errIsBus    (errIsBus),
    .errIsExpiry (errIsExpiry),
    .errIsAgent  (errIsAgent)
  );

endmodule : bprs_central_unit

// ===== sim/bprs_asserts.sv
// checker: timing relations between the central control lines
module bprs_asserts #(
  parameter int unsigned RST_HOLD_CYC     = 40,
  parameter int unsigned SAVE_CYC         = 30,
  parameter int unsigned HW_PREP_CYC      = 5,
  parameter int unsigned WRITE_PROTECT_LINE_REL_CYC     = 20,
  parameter int unsigned RECOVER_WARN_CYC = 60
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic warnN,
  input wire logic protN,
  input wire logic rstN
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] warnLow_reg;
  logic [31:0] warnLow_next;
  logic [31:0] warnHigh_reg;
  logic [31:0] warnHigh_next;
  logic [31:0] rstLow_reg;
  logic [31:0] rstLow_next;
  logic [31:0] protLow_reg;
  logic [31:0] protLow_next;

  // lengths of the current low run of each line, and of the high run of warning
  always_comb
  begin
    warnLow_next  = warnN ? 32'h0 : warnLow_reg + 32'h1;
    warnHigh_next = warnN ? warnHigh_reg + 32'h1 : 32'h0;
    rstLow_next   = rstN ? 32'h0 : rstLow_reg + 32'h1;
    protLow_next  = protN ? 32'h0 : protLow_reg + 32'h1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      warnLow_reg  <= 32'h0;
      warnHigh_reg <= 32'h0;
      rstLow_reg   <= 32'h0;
      protLow_reg  <= 32'h0;
    end
    else
    begin
      warnLow_reg  <= warnLow_next;
      warnHigh_reg <= warnHigh_next;
      rstLow_reg   <= rstLow_next;
      protLow_reg  <= protLow_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_coldLines;
    (!warnN && !rstN && protN) [*8];
  endsequence

  sequence s_warmLines;
    (warnN && protN) [*8];
  endsequence

  a_cold_lines: assert property ($rose(resetn) |-> s_coldLines)
    else $error("cold start lines wrong after reset");
  a_warn_rst_hold: assert property ($rose(warnN) && protN |-> !rstN [*8])
    else $error("reset not held after warning release");
  a_warm_only: assert property ($fell(rstN) && warnN |-> s_warmLines)
    else $error("warm start drove more than reset");
  a_rst_hold_len: assert property ($rose(rstN) |-> rstLow_reg >= RST_HOLD_CYC)
    else $error("reset released too early");
  a_save_time: assert property ($fell(protN) |-> !warnN && warnLow_reg >= SAVE_CYC)
    else $error("protect asserted before save time");
  a_hw_prep: assert property ($fell(protN) |-> (rstN && !warnN) [*4])
    else $error("power-down entered without preparation time");
  a_prep_len: assert property ($fell(rstN) && !protN |-> protLow_reg >= HW_PREP_CYC)
    else $error("power-down entered before preparation time ended");
  a_recover_warn: assert property ($rose(warnN) && !protN |->
                                   warnLow_reg >= RECOVER_WARN_CYC)
    else $error("warning after shutdown too short");
  a_write_protect_line_gap: assert property ($rose(protN) |-> warnN && warnHigh_reg >= WRITE_PROTECT_LINE_REL_CYC)
    else $error("protect released too soon after warning");
  a_fail_pattern: assert property (!protN && warnN |-> !rstN)
    else $error("protect without reset after warning release");
endmodule : bprs_asserts

// ===== sim/tb_top.sv
// testbench: both ends joined by the bus interface, error table and sequences
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int COLD = 20, HOLD = 40, SAVE = 30, PREP = 5, RECOV = 60, STAB = 8, PREL = 20;
  typedef struct packed {logic a, b, e, lb, le; int gap; logic [2:0] f;} bprs_row_t;
  // flags are bus, expiry, agent
  bprs_row_t rows [7] = '{'{1, 0, 0, 0, 0, 0, 3'h1}, '{1, 0, 0, 1, 0, 1, 3'h4},
    '{1, 1, 0, 0, 0, 0, 3'h4}, '{0, 1, 1, 0, 0, 0, 3'h6}, '{1, 0, 1, 0, 0, 0, 3'h2},
    '{1, 0, 0, 0, 1, 1, 3'h1}, '{0, 1, 0, 0, 0, 0, 3'h4}};
  logic clk_sys = 1'b0;
  logic resetn, supplyFailEarly, supplyGood, warmStartReq, batteryBackup, expiryReq;
  logic initBusy, busErrReq, agentErrReq;
  logic cuClk, cuOk, cuShut, cuRep, cuBus, cuExp, cuAgt;
  logic agPoi, agWarm, agPpf, agOk, agRep, agBus, agExp, agAgt;
  int   fails = 0;
  int   n_tests = 0;
  int   nCu, nAg, nExp;

  always #5 clk_sys = ~clk_sys;

  bprs_bus_if busIf ();
  bprs_central_unit #(.COLD_WARN_CYC(COLD), .RST_HOLD_CYC(HOLD), .SAVE_CYC(SAVE),
    .HW_PREP_CYC(PREP), .RECOVER_WARN_CYC(RECOV), .PWR_STABLE_CYC(STAB),
    .WRITE_PROTECT_LINE_REL_CYC(PREL)) bprs_central_unit_i (.clk_sys(clk_sys), .resetn(resetn),
    .supplyFailEarly(supplyFailEarly), .supplyGood(supplyGood), .warmStartReq(warmStartReq),
    .batteryBackup(batteryBackup), .expiryReq(expiryReq), .bus(busIf), .clkDriveEn(cuClk),
    .busCycleOk(cuOk), .inShutdown(cuShut), .errReport(cuRep), .errIsBus(cuBus),
    .errIsExpiry(cuExp), .errIsAgent(cuAgt));
  bprs_bus_agent bprs_bus_agent_i (.clk_sys(clk_sys), .resetn(resetn), .initBusy(initBusy),
    .busErrReq(busErrReq), .agentErrReq(agentErrReq), .bus(busIf), .powerOnInit(agPoi),
    .warmInit(agWarm), .pastPowerFail(agPpf), .busCycleOk(agOk), .errReport(agRep),
    .errIsBus(agBus), .errIsExpiry(agExp), .errIsAgent(agAgt));
  bprs_asserts #(.RST_HOLD_CYC(HOLD), .SAVE_CYC(SAVE), .HW_PREP_CYC(PREP), .WRITE_PROTECT_LINE_REL_CYC(PREL),
    .RECOVER_WARN_CYC(RECOV)) bprs_asserts_i (.clk_sys(clk_sys), .resetn(resetn),
    .warnN(busIf.warnN), .protN(busIf.protN), .rstN(busIf.rstN));

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  function automatic logic lv(input int s);
    return s == 0 ? busIf.warnN : (s == 1 ? busIf.protN : busIf.rstN);
  endfunction : lv

  // wait for a line level, bounded
  task automatic till(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (lv(s) !== v)
    begin
      if (n >= lim)
      begin
        chk("waitLimit", 32'h0, 32'h1);
        conclude();
      end
      cyc(1);
      n++;
    end
  endtask : till

  task automatic inRange(input string nm, input int n, input int lo);
    chk(nm, 32'(n >= lo && n <= lo + 2), 32'h1);
  endtask : inRange

  initial
  begin
    int n;
    int w;
    resetn = 1'b0;
    supplyFailEarly = 1'b0;
    supplyGood = 1'b1;
    warmStartReq = 1'b0;
    batteryBackup = 1'b1;
    expiryReq = 1'b0;
    initBusy = 1'b0;
    busErrReq = 1'b0;
    agentErrReq = 1'b0;
    cyc(20);
    resetn = 1'b1;
    till(2, 1'b1, 200, n);
    foreach (rows[i])
    begin
      nCu = 0;
      nAg = 0;
      nExp = 0;
      for (int k = 0; k < 12; k++)
      begin
        @(negedge clk_sys);
        agentErrReq = (k == 0) && rows[i].a;
        expiryReq = ((k == 0) && rows[i].e) || ((k == rows[i].gap) && rows[i].le);
        busErrReq = ((k == 0) && rows[i].b) || ((k == rows[i].gap) && rows[i].lb);
        nCu += (cuRep === 1'b1);
        nAg += (agRep === 1'b1);
        nExp += (busIf.expN === 1'b0);
      end
      chk("cuReports", nCu, 1);
      chk("agReports", nAg, 1);
      chk("expiryLow", nExp, rows[i].e + rows[i].le);
      chk("cuFlags", {cuBus, cuExp, cuAgt}, rows[i].f);
      chk("agFlags", {agBus, agExp, agAgt}, rows[i].f);
    end
    // second reset in mid-run, agent still initialising
    resetn = 1'b0;
    initBusy = 1'b1;
    cyc(3);
    chk("resetLines", {busIf.warnN, busIf.rstN, busIf.protN}, 3'h1);
    resetn = 1'b1;
    cyc(6);
    chk("powerOnInit", agPoi, 1'b1);
    till(0, 1'b1, COLD + 5, n);
    inRange("coldWarn", n + 6, COLD);
    till(2, 1'b1, HOLD + 5, n);
    inRange("coldRst", n, HOLD);
    cyc(5);
    chk("cuBlocked", cuOk, 1'b0);
    chk("agBlocked", agOk, 1'b0);
    initBusy = 1'b0;
    cyc(3);
    chk("cuFree", cuOk, 1'b1);
    chk("agFree", agOk, 1'b1);
    // warm start; a request inside the reset is refused
    warmStartReq = 1'b1;
    till(2, 1'b0, 5, n);
    cyc(3);
    chk("warmLines", {busIf.warnN, busIf.protN}, 2'h3);
    chk("warmInit", agWarm, 1'b1);
    warmStartReq = 1'b0;
    cyc(2);
    warmStartReq = 1'b1;
    till(2, 1'b1, HOLD + 5, n);
    inRange("warmRst", n + 5, HOLD);
    warmStartReq = 1'b0;
    cyc(10);
    chk("noRetrigger", busIf.rstN, 1'b1);
    // battery-backed power fail, warm request during shutdown
    supplyFailEarly = 1'b1;
    till(0, 1'b0, 5, n);
    cyc(3);
    chk("inShutdown", cuShut, 1'b1);
    warmStartReq = 1'b1;
    till(1, 1'b0, SAVE + 5, n);
    inRange("saveTime", n + 3, SAVE);
    w = n + 3;
    till(2, 1'b0, PREP + 5, n);
    inRange("hwPrep", n, PREP);
    w += n + 2;
    warmStartReq = 1'b0;
    supplyGood = 1'b0;
    cyc(2);
    chk("clkStopped", cuClk, 1'b0);
    supplyFailEarly = 1'b0;
    supplyGood = 1'b1;
    till(0, 1'b1, RECOV + 20, n);
    chk("warnAge", 32'(w + n >= RECOV), 32'h1);
    cyc(4);
    chk("pastFail", agPpf, 1'b1);
    chk("failLines", {busIf.protN, busIf.rstN}, 2'h0);
    till(1, 1'b1, PREL + 5, n);
    inRange("protRelease", n + 4, PREL);
    till(2, 1'b1, HOLD + 5, n);
    cyc(10);
    chk("warmIgnored", busIf.rstN, 1'b1);
    // no battery: warning only, then cold start on recovery
    batteryBackup = 1'b0;
    cyc(3);
    supplyFailEarly = 1'b1;
    till(0, 1'b0, 5, n);
    cyc(10);
    chk("noBattery", {busIf.protN, busIf.rstN}, 2'h3);
    supplyFailEarly = 1'b0;
    till(2, 1'b0, 10, n);
    chk("coldAfter", busIf.warnN, 1'b0);
    till(2, 1'b1, COLD + HOLD + 10, n);
    // power fail inside a warm reset is not sequenced
    batteryBackup = 1'b1;
    warmStartReq = 1'b1;
    till(2, 1'b0, 5, n);
    cyc(8);
    supplyFailEarly = 1'b1;
    cyc(10);
    chk("abandon", {busIf.warnN, busIf.protN, busIf.rstN}, 3'h2);
    supplyFailEarly = 1'b0;
    warmStartReq = 1'b0;
    till(2, 1'b1, COLD + HOLD + 15, n);
    chk("runAgain", cuOk, 1'b1);
    conclude();
  end
endmodule : tb_top
